// file: ebi_pkg.sv
package ebi_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_SPACES = 4;
  localparam int WAIT_W = 3;

  // processor mode codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;
  localparam logic [1:0] MODE_PROC = 2'h3;

  // bus format codes
  localparam logic [1:0] FMT_SEPARATE = 2'h0;
  localparam logic [1:0] FMT_MUX_AREA1 = 2'h1;
  localparam logic [1:0] FMT_MUX_AREA2 = 2'h2;
  localparam logic [1:0] FMT_MUX_ALL = 2'h3;

  // latch strobe pin routing
  localparam logic [1:0] LATCH_NONE = 2'h0;
  localparam logic [1:0] LATCH_CLOCK_PIN = 2'h1;
  localparam logic [1:0] LATCH_DEFAULT_PIN = 2'h2;
  localparam logic [1:0] LATCH_GRANT_PIN = 2'h3;

  // values after reset
  localparam logic [1:0] RST_PROC_MODE = MODE_PROC;
  localparam logic [1:0] RST_FORMAT = FMT_SEPARATE;
  localparam logic [1:0] RST_SPACE_MODE = 2'h0;
  localparam logic RST_STROBE_SCHEME = 1'b0;
  localparam logic [1:0] RST_LATCH_SEL = LATCH_DEFAULT_PIN;
  localparam logic [WAIT_W-1:0] RST_WAIT = 3'h1;
  localparam logic [NUM_SPACES-1:0] RST_WIDTH = 4'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam int STRAP_SPACE = 3;

  typedef struct packed {
    logic [1:0] proc_mode;
    logic bus_format_hi_bit;
    logic bus_format_lo_bit;
    logic space_mode_hi_bit;
    logic space_mode_lo_bit;
    logic strobe_scheme_bit;
    logic latch_pin_sel_hi;
    logic latch_pin_sel_lo;
    logic [NUM_SPACES-1:0][WAIT_W-1:0] space_wait_config;
  } ebi_cfg_s;

  typedef struct packed {
    logic ext;
    logic we;
    logic [1:0] space;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebi_req_s;

  typedef struct packed {
    logic ad_lo;
    logic ad_hi;
    logic addr_mid;
    logic top_pins;
    logic data_lo;
    logic data_hi;
    logic strobes;
  } ebi_pins_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STROBE = 2'b10,
    ST_END = 2'b11
  } ebi_state_e;

endpackage

// file: ebi_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - bus pins active only in expansion/processor mode
// - per-space 8/16-bit width from width bits
// - space 3 width follows strap after reset
// - internal data path always 16 bits
// - high data port used only if any 16-bit
// - upper lane indeterminate on 8-bit access
// - per-space wait count on both formats
// - mux shares data with low address lines
// - format field picks separate or multiplexed areas
// - all-mux outputs address 0-15 and the top four pins only
// - 24-bit address, top bit inverted
// - address indeterminate until first external access
// - space mode sets address lines and selects
// - up to four selects share address 20-23
// - no select after reset in processor mode
// - select low only for its own area
// - address/select update rules between cycles
// - strobe scheme bit; 8-bit forces enable scheme
// - reset uses read/write/upper-enable scheme
// - latch pin select; none leaves default undefined
// - upper enable and address bit 0 encoding
module ebi_core (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic bus_clk_i,
  input wire logic width_strap_i,
  input wire logic cfg_wr_i,
  input wire ebi_pkg::ebi_cfg_s cfg_i,
  input wire logic width_wr_i,
  input wire logic [ebi_pkg::NUM_SPACES-1:0] space_width_select_i,
  input wire logic req_valid_i,
  input wire ebi_pkg::ebi_req_s req_i,
  input wire logic [ebi_pkg::DATA_W-1:0] data_i,
  input wire logic [ebi_pkg::DATA_W-1:0] ad_i,
  output ebi_pkg::ebi_cfg_s cfg_o,
  output logic [ebi_pkg::NUM_SPACES-1:0] space_width_select_o,
  output ebi_pkg::ebi_pins_s pin_func_o,
  output logic busy_o,
  output logic done_o,
  output logic [ebi_pkg::DATA_W-1:0] rdata_o,
  output logic [ebi_pkg::DATA_W-1:0] data_o,
  output logic [ebi_pkg::DATA_W-1:0] data_oe_o,
  output logic [ebi_pkg::DATA_W-1:0] ad_o,
  output logic [ebi_pkg::DATA_W-1:0] ad_oe_o,
  output logic [3:0] addr_mid_o,
  output logic [3:0] top_pins_o,
  output logic read_strobe_n_o,
  output logic low_lane_store_strobe_n_o,
  output logic upper_lane_enable_n_o,
  output logic [2:0] latch_pins_o
);

  // number of select pins taken from the top of the address
  function automatic logic [2:0] sel_count(input logic [1:0] mode);
    case (mode)
      2'h1: sel_count = 3'h3;
      2'h2: sel_count = 3'h2;
      2'h3: sel_count = 3'h4;
      default: sel_count = 3'h0;
    endcase
  endfunction

  function automatic logic area_muxed(input logic [1:0] fmt,
                                      input logic [1:0] space);
    area_muxed = (fmt == ebi_pkg::FMT_MUX_ALL) ||
      (fmt == ebi_pkg::FMT_MUX_AREA1 && space == 2'h1) ||
      (fmt == ebi_pkg::FMT_MUX_AREA2 && space == 2'h2);
  endfunction

  // ---------------- cpu clock domain ----------------
  ebi_pkg::ebi_cfg_s cfg;
  logic [ebi_pkg::NUM_SPACES-1:0] width;
  logic [2:0] strap_sync;
  logic [1:0] strap_cnt;
  logic strap_done;
  ebi_pkg::ebi_req_s hold_req;
  ebi_pkg::ebi_cfg_s hold_cfg;
  logic [ebi_pkg::NUM_SPACES-1:0] hold_width;
  logic req_tgl;
  logic [2:0] ack_sync;
  logic ack_seen;
  logic [ebi_pkg::DATA_W-1:0] link_rdata;
  logic ack_tgl;
  logic bus_on;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg.proc_mode <= ebi_pkg::RST_PROC_MODE;
      {cfg.bus_format_hi_bit, cfg.bus_format_lo_bit} <= ebi_pkg::RST_FORMAT;
      {cfg.space_mode_hi_bit, cfg.space_mode_lo_bit} <=
        ebi_pkg::RST_SPACE_MODE;
      cfg.strobe_scheme_bit <= ebi_pkg::RST_STROBE_SCHEME;
      {cfg.latch_pin_sel_hi, cfg.latch_pin_sel_lo} <= ebi_pkg::RST_LATCH_SEL;
      cfg.space_wait_config <= {ebi_pkg::NUM_SPACES{ebi_pkg::RST_WAIT}};
    end else if (cfg_wr_i) begin
      cfg <= cfg_i;
    end
  end

  // strap is a pin: three flops, taken once the last two agree
  always_ff @(posedge clk_i) begin
    strap_sync <= {strap_sync[1:0], width_strap_i};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == ebi_pkg::STRAP_SETTLE) begin
        if (strap_sync[2] == strap_sync[1]) begin
          strap_done <= 1'b1;
        end
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // the strap is caught once; the board must not move it later
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      width <= ebi_pkg::RST_WIDTH;
    end else if (width_wr_i) begin
      width <= space_width_select_i;
    end else if (!strap_done && strap_cnt == ebi_pkg::STRAP_SETTLE &&
                 strap_sync[2] == strap_sync[1]) begin
      width[ebi_pkg::STRAP_SPACE] <= ~strap_sync[2];
    end
  end

  assign bus_on = (cfg.proc_mode == ebi_pkg::MODE_EXPAND) ||
                  (cfg.proc_mode == ebi_pkg::MODE_PROC);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_func_o <= '0;
    end else begin
      pin_func_o.ad_lo <= bus_on;
      pin_func_o.ad_hi <= bus_on;
      pin_func_o.top_pins <= bus_on;
      pin_func_o.strobes <= bus_on;
      pin_func_o.addr_mid <= bus_on && {cfg.bus_format_hi_bit,
        cfg.bus_format_lo_bit} != ebi_pkg::FMT_MUX_ALL;
      pin_func_o.data_lo <= bus_on && {cfg.bus_format_hi_bit,
        cfg.bus_format_lo_bit} != ebi_pkg::FMT_MUX_ALL;
      pin_func_o.data_hi <= bus_on && (|width) && {cfg.bus_format_hi_bit,
        cfg.bus_format_lo_bit} != ebi_pkg::FMT_MUX_ALL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_o <= '0;
      space_width_select_o <= '0;
    end else begin
      cfg_o <= cfg;
      space_width_select_o <= width;
    end
  end

  // request crossing: hold the word stable until the toggle comes back
  always_ff @(posedge clk_i) begin
    ack_sync <= {ack_sync[1:0], ack_tgl};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_tgl <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ack_seen <= 1'b0;
      rdata_o <= '0;
      hold_req <= '0;
      hold_cfg <= '0;
      hold_width <= '0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o && req_valid_i && bus_on) begin
        hold_req <= req_i;
        hold_cfg <= cfg;
        hold_width <= width;
        req_tgl <= ~req_tgl;
        busy_o <= 1'b1;
      end else if (busy_o && ack_sync[2] == ack_sync[1] &&
                   ack_sync[2] != ack_seen) begin
        ack_seen <= ack_sync[2];
        busy_o <= 1'b0;
        done_o <= 1'b1;
        rdata_o <= link_rdata;
      end
    end
  end

  // ---------------- bus clock domain ----------------
  logic [2:0] lrst_sync;
  logic lrst_n;
  logic [2:0] req_sync;
  logic req_seen;
  logic start;
  ebi_pkg::ebi_state_e state;
  ebi_pkg::ebi_req_s cur;
  ebi_pkg::ebi_cfg_s ccfg;
  logic wide;
  logic muxed;
  logic [ebi_pkg::WAIT_W-1:0] wait_cnt;
  logic lane_scheme;
  logic [7:0] wbyte;
  logic odd_only;
  logic [2:0] nsel;
  logic [3:0] next_top;
  logic [ebi_pkg::DATA_W-1:0] rbus;

  always_ff @(posedge bus_clk_i) begin
    lrst_sync <= {lrst_sync[1:0], rst_n_i};
  end
  assign lrst_n = lrst_sync[2] & lrst_sync[1];

  always_ff @(posedge bus_clk_i) begin
    req_sync <= {req_sync[1:0], req_tgl};
  end
  assign start = (state == ebi_pkg::ST_IDLE) &&
                 req_sync[2] == req_sync[1] && req_sync[2] != req_seen;

  assign nsel = sel_count({hold_cfg.space_mode_hi_bit,
                           hold_cfg.space_mode_lo_bit});
  assign odd_only = (cur.byte_en == 2'b10);
  assign wbyte = cur.byte_en[1] && !cur.byte_en[0] ? cur.wdata[15:8] :
                 cur.wdata[7:0];
  assign rbus = muxed ? ad_i : data_i;

  // top four pins: select where the space mode claims them, else address
  always_comb begin
    next_top = '0;
    for (int k = 0; k < 4; k++) begin
      if (3'(3 - k) < nsel) begin
        next_top[k] = (hold_req.space != 2'(3 - k));
      end else if (k == 3) begin
        next_top[k] = ~hold_req.addr[23];
      end else begin
        next_top[k] = hold_req.addr[20 + k];
      end
    end
  end

  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      state <= ebi_pkg::ST_IDLE;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      wait_cnt <= '0;
      cur <= '0;
      ccfg <= '0;
      wide <= 1'b0;
      muxed <= 1'b0;
      lane_scheme <= 1'b0;
    end else begin
      case (state)
        ebi_pkg::ST_IDLE: begin
          if (start) begin
            req_seen <= req_sync[2];
            cur <= hold_req;
            ccfg <= hold_cfg;
            wide <= hold_width[hold_req.space];
            muxed <= area_muxed({hold_cfg.bus_format_hi_bit,
              hold_cfg.bus_format_lo_bit}, hold_req.space);
            // an 8-bit space always runs the upper-enable scheme
            lane_scheme <= hold_cfg.strobe_scheme_bit &&
                           hold_width[hold_req.space];
            if (hold_req.ext) begin
              state <= ebi_pkg::ST_ADDR;
            end else begin
              ack_tgl <= ~ack_tgl;
            end
          end
        end
        ebi_pkg::ST_ADDR: begin
          wait_cnt <= ccfg.space_wait_config[cur.space];
          state <= ebi_pkg::ST_STROBE;
        end
        ebi_pkg::ST_STROBE: begin
          if (wait_cnt == '0) begin
            state <= ebi_pkg::ST_END;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: begin
          ack_tgl <= ~ack_tgl;
          state <= ebi_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // address and select pins; address moves only on an external access, selects also go inactive on an internal one
  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      ad_o <= '0;
      addr_mid_o <= '0;
      top_pins_o <= 4'hF;
    end else if (start && hold_req.ext) begin
      ad_o <= hold_req.addr[15:0];
      addr_mid_o <= hold_req.addr[19:16];
      top_pins_o <= next_top;
    end else if (start) begin
      // internal cycle: address holds, selects go inactive
      for (int k = 0; k < 4; k++) begin
        if (3'(3 - k) < nsel) begin
          top_pins_o[k] <= 1'b1;
        end
      end
    end else if (state == ebi_pkg::ST_ADDR && muxed && cur.we) begin
      if (wide) begin
        ad_o <= cur.wdata;
      end else begin
        ad_o[7:0] <= wbyte;
      end
    end else if (state == ebi_pkg::ST_END && muxed) begin
      ad_o <= cur.addr[15:0];
    end
  end

  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      ad_oe_o <= '0;
    end else if (state == ebi_pkg::ST_ADDR && muxed) begin
      // shared lines turn round for the data phase
      if (wide) begin
        ad_oe_o <= {ebi_pkg::DATA_W{cur.we}};
      end else begin
        ad_oe_o <= {8'hFF, {8{cur.we}}};
      end
    end else if (start && hold_req.ext) begin
      ad_oe_o <= 16'hFFFF;
    end else if (state == ebi_pkg::ST_END) begin
      ad_oe_o <= 16'hFFFF;
    end
  end

  // separate data port; upper lane of an 8-bit access is don't-care
  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      data_o <= '0;
      data_oe_o <= '0;
    end else if (state == ebi_pkg::ST_ADDR && !muxed && cur.we) begin
      data_o <= wide ? cur.wdata : {wbyte, wbyte};
      data_oe_o <= {{8{|hold_width}}, 8'hFF};
    end else if (state == ebi_pkg::ST_END) begin
      data_oe_o <= '0;
    end
  end

  // strobes: asserted through the wait states; upper enable stays low after them unless lane_scheme
  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      read_strobe_n_o <= 1'b1;
      low_lane_store_strobe_n_o <= 1'b1;
      upper_lane_enable_n_o <= 1'b1;
    end else if (state == ebi_pkg::ST_ADDR) begin
      read_strobe_n_o <= cur.we;
      if (lane_scheme) begin
        low_lane_store_strobe_n_o <= !(cur.we && cur.byte_en[0]);
        upper_lane_enable_n_o <= !(cur.we && cur.byte_en[1]);
      end else begin
        low_lane_store_strobe_n_o <= !cur.we;
        upper_lane_enable_n_o <= !(wide && cur.byte_en[1]);
      end
    end else if (state == ebi_pkg::ST_STROBE && wait_cnt == '0) begin
      read_strobe_n_o <= 1'b1;
      low_lane_store_strobe_n_o <= 1'b1;
      if (lane_scheme) begin
        upper_lane_enable_n_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      link_rdata <= '0;
    end else if (state == ebi_pkg::ST_STROBE && wait_cnt == '0 &&
                 !cur.we) begin
      if (wide) begin
        link_rdata <= rbus;
      end else if (cur.addr[0]) begin
        link_rdata <= {rbus[7:0], 8'h00};
      end else begin
        link_rdata <= {8'h00, rbus[7:0]};
      end
    end
  end

  // latch strobe high for the address phase of a multiplexed access
  always_ff @(posedge bus_clk_i) begin
    if (!lrst_n) begin
      latch_pins_o <= '0;
    end else begin
      latch_pins_o <= '0;
      if (start && hold_req.ext && area_muxed({hold_cfg.bus_format_hi_bit,
          hold_cfg.bus_format_lo_bit}, hold_req.space)) begin
        case ({hold_cfg.latch_pin_sel_hi, hold_cfg.latch_pin_sel_lo})
          ebi_pkg::LATCH_DEFAULT_PIN: latch_pins_o[0] <= 1'b1;
          ebi_pkg::LATCH_CLOCK_PIN: latch_pins_o[1] <= 1'b1;
          ebi_pkg::LATCH_GRANT_PIN: latch_pins_o[2] <= 1'b1;
          default: latch_pins_o <= '0;
        endcase
      end
    end
  end

  // ---------------- checks ----------------
  logic [3:0] strobe_len;
  always_ff @(posedge bus_clk_i) begin
    if (state == ebi_pkg::ST_ADDR) begin
      strobe_len <= 4'h0;
    end else if (state == ebi_pkg::ST_STROBE) begin
      strobe_len <= strobe_len + 4'h1;
    end
  end

  AST_WAIT_LEN: assert property (@(posedge bus_clk_i) disable iff (!lrst_n)
    state == ebi_pkg::ST_STROBE && wait_cnt == '0 |->
    strobe_len == 4'(ccfg.space_wait_config[cur.space]))
    else $error("strobe phase length differs from wait setting");

  AST_SEL_OWN_AREA: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    start && hold_req.ext && nsel == 3'h4 |=>
    top_pins_o == ~(4'h8 >> $past(hold_req.space)))
    else $error("select pin not low for accessed area");

  AST_TOP_INVERTED: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    start && hold_req.ext && nsel == 3'h0 |=>
    top_pins_o[3] == ~$past(hold_req.addr[23]))
    else $error("top address pin not inverted");

  AST_INTERNAL_HOLD: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    start && !hold_req.ext |=> $stable(ad_o) && $stable(addr_mid_o))
    else $error("address moved on internal cycle");

  AST_IDLE_HOLD: assert property (@(posedge bus_clk_i) disable iff (!lrst_n)
    state == ebi_pkg::ST_IDLE && !start && !muxed |=>
    $stable(top_pins_o) && $stable(ad_o))
    else $error("bus pins moved in idle cycle");

  AST_BYTE_SCHEME: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && !wide && cur.we |=>
    !low_lane_store_strobe_n_o && upper_lane_enable_n_o)
    else $error("8-bit write not on write/enable scheme");

  AST_READ_STROBES: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && !cur.we |=>
    !read_strobe_n_o && low_lane_store_strobe_n_o ##1
    low_lane_store_strobe_n_o)
    else $error("read with a store strobe active");

  AST_UPPER_ENABLE: assert property (@(posedge bus_clk_i)
    disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && !lane_scheme && wide && odd_only |=>
    !upper_lane_enable_n_o)
    else $error("odd byte without upper enable");

  AST_MUX_DATA: assert property (@(posedge bus_clk_i) disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && muxed && cur.we && !wide |=>
    ad_o[7:0] == $past(wbyte) && ad_oe_o[7:0] == 8'hFF)
    else $error("mux write data not on shared lines");

  AST_SINGLE_CHIP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.proc_mode == ebi_pkg::MODE_SINGLE |=> pin_func_o == '0)
    else $error("bus pins claimed in single-chip mode");

  AST_ALL_MUX_PINS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.bus_format_hi_bit && cfg.bus_format_lo_bit |=>
    !pin_func_o.data_lo && !pin_func_o.data_hi && !pin_func_o.addr_mid)
    else $error("all-mux format left data ports claimed");

  COV_MUX_WRITE: cover property (@(posedge bus_clk_i) disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && muxed && cur.we);
  COV_SEP_READ16: cover property (@(posedge bus_clk_i) disable iff (!lrst_n)
    state == ebi_pkg::ST_ADDR && !muxed && wide && !cur.we);
  COV_INTERNAL: cover property (@(posedge bus_clk_i) disable iff (!lrst_n)
    start && !hold_req.ext);

endmodule // ebi_core

// file: ebi_mem_model.sv
`timescale 1ns/10ps
module ebi_mem_model (
  input wire logic bus_clk_i,
  input wire logic read_strobe_n_i,
  input wire logic [ebi_pkg::DATA_W-1:0] addr_i,
  output logic [ebi_pkg::DATA_W-1:0] data_o,
  output logic [ebi_pkg::DATA_W-1:0] ad_o
);
  logic [ebi_pkg::DATA_W-1:0] last;
  initial begin
    last = 16'h0000;
    data_o = 16'hFFFF;
    ad_o = 16'hFFFF;
  end
  // answers only under the read strobe; released lines invert, but ad_o returns to old data a cycle later
  always @(posedge bus_clk_i) begin
    if (!read_strobe_n_i) begin
      last <= addr_i ^ 16'h5A3C;
      data_o <= addr_i ^ 16'h5A3C;
      ad_o <= addr_i ^ 16'h5A3C;
    end else begin
      data_o <= ~last;
      ad_o <= ~data_o;
    end
  end
endmodule // ebi_mem_model

// file: external_bus_interface_tb.sv
`timescale 1ns/10ps
module external_bus_interface_tb;
  logic clk_i, bus_clk_i, rst_n_i, cfg_wr_i, width_wr_i, req_valid_i;
  logic [3:0] wsel;
  ebi_pkg::ebi_cfg_s cfg_i, cfg_o;
  ebi_pkg::ebi_req_s req_i;
  ebi_pkg::ebi_pins_s pin_func_o;
  logic [3:0] space_width_select_o, addr_mid_o, top_pins_o;
  logic [15:0] data_i, ad_i, rdata_o, data_o, data_oe_o, ad_o, ad_oe_o;
  logic busy_o, done_o, rd_n, lo_n, up_n, saw_lo, saw_hi, saw_ale;
  logic [2:0] latch_pins_o;
  int errors = 0, n_compared = 0, cyc = 0;

  ebi_core i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_clk_i(bus_clk_i),
    .width_strap_i(1'b0), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i),
    .width_wr_i(width_wr_i), .space_width_select_i(wsel),
    .req_valid_i(req_valid_i), .req_i(req_i), .data_i(data_i), .ad_i(ad_i),
    .cfg_o(cfg_o), .space_width_select_o(space_width_select_o),
    .pin_func_o(pin_func_o), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .data_o(data_o), .data_oe_o(data_oe_o), .ad_o(ad_o),
    .ad_oe_o(ad_oe_o), .addr_mid_o(addr_mid_o), .top_pins_o(top_pins_o),
    .read_strobe_n_o(rd_n), .low_lane_store_strobe_n_o(lo_n),
    .upper_lane_enable_n_o(up_n), .latch_pins_o(latch_pins_o));
  ebi_mem_model i_mem (.bus_clk_i(bus_clk_i), .read_strobe_n_i(rd_n),
    .addr_i(ad_o), .data_o(data_i), .ad_o(ad_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    bus_clk_i = 1'b0;
    #1.3;
    forever #3 bus_clk_i = ~bus_clk_i;
  end
  // lane strobes are seen in the bus domain, so flag them there
  always @(posedge bus_clk_i) begin
    if (!lo_n) saw_lo <= 1'b1;
    if (!up_n) saw_hi <= 1'b1;
    if (latch_pins_o[0]) saw_ale <= 1'b1;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic set_cfg(logic [1:0] mode, logic scheme,
                         logic [1:0] fmt = 2'h0, logic [1:0] smode = 2'h0);
    ebi_pkg::ebi_cfg_s c;
    c = '0;
    c.proc_mode = mode;
    c.strobe_scheme_bit = scheme;
    {c.bus_format_hi_bit, c.bus_format_lo_bit} = fmt;
    {c.space_mode_hi_bit, c.space_mode_lo_bit} = smode;
    c.latch_pin_sel_hi = 1'b1;
    c.space_wait_config = {4{3'h1}};
    @(posedge clk_i);
    cfg_i <= c;
    cfg_wr_i <= 1'b1;
    wsel <= 4'h8;
    width_wr_i <= 1'b1;
    @(posedge clk_i);
    cfg_wr_i <= 1'b0;
    width_wr_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic req(logic ext, we, logic [1:0] sp, be, logic [23:0] a);
    int n;
    @(posedge clk_i);
    req_i <= '{ext, we, sp, be, a, 16'hC33C};
    req_valid_i <= 1'b1;
    saw_lo <= 1'b0;
    saw_hi <= 1'b0;
    saw_ale <= 1'b0;
    n = 0;
    do begin @(negedge clk_i); n++; end while (busy_o !== 1'b1 && n < 20);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do begin @(negedge clk_i); n++; end while (done_o !== 1'b1 && n < 200);
    chk("done", 16'h1, {15'h0, done_o});
  endtask

  task automatic t_reset();
    chk("proc mode", 16'h3, {14'h0, cfg_o.proc_mode});
    chk("strobe scheme", 16'h0, {15'h0, cfg_o.strobe_scheme_bit});
    chk("widths", 16'h8, {12'h0, space_width_select_o});
    chk("space mode", 16'h0, {14'h0, cfg_o.space_mode_hi_bit,
      cfg_o.space_mode_lo_bit});
    chk("addr drive", 16'h0, ad_oe_o);
  endtask

  task automatic t_single();
    int n;
    set_cfg(ebi_pkg::MODE_SINGLE, 1'b0);
    chk("pin func", 16'h0, {9'h0, pin_func_o});
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    n = 0;
    repeat (20) begin
      @(negedge clk_i);
      n += int'(busy_o !== 1'b0);
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    chk("busy in single", 16'h0, 16'(n));
  endtask

  task automatic t_read();
    set_cfg(ebi_pkg::MODE_EXPAND, 1'b0);
    chk("pin func exp", 16'h7F, {9'h0, pin_func_o});
    req(1'b1, 1'b0, 2'h3, 2'h3, 24'h000124);
    chk("rdata 16", 16'h0124 ^ 16'h5A3C, rdata_o);
    req(1'b1, 1'b0, 2'h0, 2'h2, 24'h850201);
    chk("rdata 8 odd", 16'h003D, {8'h0, rdata_o[15:8]});
    chk("top pins", 16'h0, {12'h0, top_pins_o});
    chk("addr mid", 16'h5, {12'h0, addr_mid_o});
    req(1'b0, 1'b0, 2'h0, 2'h3, 24'h000400);
    chk("addr held", 16'h0201, ad_o);
  endtask

  task automatic t_select();
    set_cfg(ebi_pkg::MODE_EXPAND, 1'b0, 2'h0, 2'h3);
    req(1'b1, 1'b0, 2'h1, 2'h3, 24'h000040);
    chk("select space 1", 16'hB, {12'h0, top_pins_o});
    req(1'b0, 1'b0, 2'h0, 2'h3, 24'h000000);
    chk("select off", 16'hF, {12'h0, top_pins_o});
    chk("addr kept", 16'h0040, ad_o);
  endtask

  task automatic t_mux();
    set_cfg(ebi_pkg::MODE_EXPAND, 1'b0, ebi_pkg::FMT_MUX_ALL);
    chk("pin func mux", 16'h69, {9'h0, pin_func_o});
    req(1'b1, 1'b0, 2'h3, 2'h3, 24'h000356);
    chk("mux rdata", 16'h0356 ^ 16'h5A3C, rdata_o);
    chk("latch pulse", 16'h1, {15'h0, saw_ale});
    req(1'b1, 1'b1, 2'h0, 2'h1, 24'h000012);
    chk("mux addr back", 16'h0012, ad_o);
    chk("mux ad drive", 16'hFFFF, ad_oe_o);
  endtask

  task automatic t_write(logic sch, logic [1:0] sp, be, logic el, eh,
                         logic [15:0] ed);
    set_cfg(ebi_pkg::MODE_EXPAND, sch);
    req(1'b1, 1'b1, sp, be, 24'h000010);
    chk("write data", ed, data_o);
    chk("low strobe", {15'h0, el}, {15'h0, saw_lo});
    chk("high strobe", {15'h0, eh}, {15'h0, saw_hi});
  endtask

  initial begin
    rst_n_i = 1'b0;
    cfg_wr_i = 1'b0;
    width_wr_i = 1'b0;
    wsel = 4'h0;
    cfg_i = '0;
    req_valid_i = 1'b0;
    req_i = '0;
    saw_lo = 1'b0;
    saw_hi = 1'b0;
    saw_ale = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    t_reset();
    t_single();
    t_read();
    t_select();
    t_mux();
    t_write(1'b1, 2'h3, 2'h2, 1'b0, 1'b1, 16'hC33C);
    t_write(1'b1, 2'h0, 2'h1, 1'b1, 1'b0, 16'h3C3C);
    t_write(1'b0, 2'h3, 2'h3, 1'b1, 1'b1, 16'hC33C);
    report_and_stop();
  end
endmodule // external_bus_interface_tb
